// ==== lcdc_disp_mem.sv ====
// Display data memory with one write port and two registered read ports
`timescale 1ns/1ns
`default_nettype none

module lcdc_disp_mem #(
  parameter int unsigned DEPTH = 37,
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 6
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic [AW-1:0]    i_cpu_addr,
  output logic      [WIDTH-1:0] o_cpu_data,
  input  wire logic [AW-1:0]    i_scan_addr,
  output logic      [WIDTH-1:0] o_scan_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Contents have no reset, as ordinary data memory
  always_ff @(posedge i_clock) begin
    if (i_wr_en && (i_wr_addr < AW'(DEPTH))) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_cpu_data <= '0;
    end else if (i_cpu_addr < AW'(DEPTH)) begin
      o_cpu_data <= mem_q[i_cpu_addr];
    end else begin
      o_cpu_data <= '0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_scan_data <= '0;
    end else if (i_scan_addr < AW'(DEPTH)) begin
      o_scan_data <= mem_q[i_scan_addr];
    end else begin
      o_scan_data <= '0;
    end
  end

endmodule

`default_nettype wire

// ==== lcdc_panel_model.sv ====
// Passive glass panel model: records what each common slot shows
`timescale 1ns/1ns
`default_nettype none

module lcdc_panel_model (
  input  wire logic        i_clock,
  input  wire logic [36:0] i_segments,
  input  wire logic [3:0]  i_commons
);
  logic [36:0] seg_seen [4];
  logic [3:0]  prev_com = 4'h0;
  int          max_com = 0;
  int          order_err = 0;
  int          slot_len = 0;
  int          cnt = 0;

  // ----------------------------------------------------------------
  // Slot tracking
  // ----------------------------------------------------------------
  // one common at a time, ascending
  always @(posedge i_clock) begin
    cnt <= cnt + 1;
    for (int c = 0; c < 4; c++) begin
      if (i_commons == 4'(1 << c)) begin
        seg_seen[c] <= i_segments;
        if (c > max_com) begin
          max_com <= c;
        end
      end
    end
    if (!$onehot0(i_commons)) begin
      order_err <= order_err + 1;
    end
    if (i_commons !== prev_com) begin
      // Wrap to common 0 is legal at any slot
      if (prev_com != 4'h0 && i_commons != 4'h0 && i_commons != 4'h1
          && i_commons != (prev_com << 1)) begin
        order_err <= order_err + 1;
      end
      slot_len <= cnt;
      cnt <= 1;
    end
    prev_com <= i_commons;
  end
endmodule

`default_nettype wire

// ==== lcdc_pkg.sv ====
// Constants and types shared by the segment LCD controller files
package lcdc_pkg;

  // ----------------------------------------------------------------
  // Register bus map
  // ----------------------------------------------------------------
  localparam int unsigned AXI_ADDR_WIDTH   = 12;
  localparam logic [11:0] CTRL_ADDR        = 12'h000;
  localparam logic [11:0] PAGE_ADDR        = 12'h004;
  // Display window indexes; byte address is four times the index
  localparam logic [9:0]  DISP_FIRST_INDEX = 10'h100;
  localparam logic [9:0]  DISP_LAST_INDEX  = 10'h124;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned RATE_LSB   = 0;
  localparam int unsigned DUTY_LSB   = 2;
  localparam int unsigned ENABLE_BIT = 4;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  CTRL_MASK  = 8'h1f;
  localparam logic [7:0]  PAGE_RESET = 8'h00;
  localparam logic [7:0]  DISP_PAGE  = 8'h01;

  // ----------------------------------------------------------------
  // Panel geometry and scan counts
  // ----------------------------------------------------------------
  localparam int unsigned SEG_COUNT    = 37;
  localparam int unsigned COM_COUNT    = 4;
  localparam int unsigned DISP_DEPTH   = 37;
  localparam logic [5:0]  SEG_LAST     = 6'h24;
  localparam logic [5:0]  FETCH_LAST   = 6'h25;
  localparam logic [8:0]  BASE_DIV_MIN = 9'h020;

  typedef enum logic [1:0] {
    DUTY_STATIC  = 2'b00,
    DUTY_HALF    = 2'b01,
    DUTY_THIRD   = 2'b10,
    DUTY_QUARTER = 2'b11
  } lcdc_duty_type;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_FETCH = 2'b01,
    ST_WAIT  = 2'b10
  } lcdc_state_type;

  typedef enum logic [1:0] {
    DEC_NONE = 2'b00,
    DEC_CTRL = 2'b01,
    DEC_PAGE = 2'b10,
    DEC_DISP = 2'b11
  } lcdc_dec_type;

endpackage

// ==== lcdc_segment_lcd_controller.sv ====
// Segment LCD controller: AXI4-Lite registers, display memory, common/segment scan
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module lcdc_segment_lcd_controller
  import lcdc_pkg::*;
(
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire logic                      i_sub_clock,
  input  wire logic [AXI_ADDR_WIDTH-1:0] i_s_axi_awaddr,
  input  wire logic [2:0]                i_s_axi_awprot,
  input  wire logic                      i_s_axi_awvalid,
  output logic                           o_s_axi_awready,
  input  wire logic [31:0]               i_s_axi_wdata,
  input  wire logic [3:0]                i_s_axi_wstrb,
  input  wire logic                      i_s_axi_wvalid,
  output logic                           o_s_axi_wready,
  output logic [1:0]                     o_s_axi_bresp,
  output logic                           o_s_axi_bvalid,
  input  wire logic                      i_s_axi_bready,
  input  wire logic [AXI_ADDR_WIDTH-1:0] i_s_axi_araddr,
  input  wire logic [2:0]                i_s_axi_arprot,
  input  wire logic                      i_s_axi_arvalid,
  output logic                           o_s_axi_arready,
  output logic [31:0]                    o_s_axi_rdata,
  output logic [1:0]                     o_s_axi_rresp,
  output logic                           o_s_axi_rvalid,
  input  wire logic                      i_s_axi_rready,
  output logic [SEG_COUNT-1:0]           o_segment_outputs,
  output logic [COM_COUNT-1:0]           o_common_outputs,
  output logic                           o_frame_polarity
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic lcdc_dec_type decode(input logic [11:0] addr, input logic [7:0] page);
    logic [9:0] idx;
    idx = addr[11:2];
    if (idx == CTRL_ADDR[11:2]) begin
      decode = DEC_CTRL;
    end else if (idx == PAGE_ADDR[11:2]) begin
      decode = DEC_PAGE;
    end else if (idx >= DISP_FIRST_INDEX && idx <= DISP_LAST_INDEX && page == DISP_PAGE) begin
      decode = DEC_DISP;
    end else begin
      decode = DEC_NONE;
    end
  endfunction

  function automatic logic [5:0] disp_index(input logic [11:0] addr);
    logic [9:0] off;
    off = addr[11:2] - DISP_FIRST_INDEX;
    disp_index = off[5:0];
  endfunction

  logic [7:0]     display_control_reg_q;
  logic [7:0]     ram_page_select_q;
  logic           aw_full_q;
  logic           w_full_q;
  logic [11:0]    waddr_q;
  logic [7:0]     wdata_q;
  logic           wstrb0_q;
  logic           bvalid_q;
  logic [1:0]     bresp_q;
  logic           rwait_q;
  logic           rvalid_q;
  lcdc_dec_type   rdec_q;
  logic [31:0]    rdata_q;
  logic [1:0]     rresp_q;
  logic [7:0]     cpu_rd_data;
  logic [7:0]     scan_rd_data;

  lcdc_dec_type   wr_dec;
  logic           do_write;
  logic           ar_hs;
  logic           ctrl_wr;
  logic           mem_wr;

  assign o_s_axi_awready = !aw_full_q && !bvalid_q;
  assign o_s_axi_wready  = !w_full_q && !bvalid_q;
  assign o_s_axi_arready = !rwait_q && !rvalid_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

  assign wr_dec   = decode(waddr_q, ram_page_select_q);
  assign do_write = aw_full_q && w_full_q;
  assign ar_hs    = i_s_axi_arvalid && o_s_axi_arready;
  assign ctrl_wr  = do_write && wr_dec == DEC_CTRL && wstrb0_q;
  assign mem_wr   = do_write && wr_dec == DEC_DISP && wstrb0_q;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is parked
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      aw_full_q <= 1'b0;
      waddr_q   <= '0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_full_q <= 1'b1;
      waddr_q   <= i_s_axi_awaddr;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb0_q <= 1'b0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= i_s_axi_wdata[7:0];
      wstrb0_q <= i_s_axi_wstrb[0];
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_dec == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (i_s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      display_control_reg_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      display_control_reg_q <= wdata_q & CTRL_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ram_page_select_q <= PAGE_RESET;
    end else if (do_write && wr_dec == DEC_PAGE && wstrb0_q) begin
      ram_page_select_q <= wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One wait cycle covers the registered memory read
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rwait_q <= 1'b0;
      rdec_q  <= DEC_NONE;
    end else if (ar_hs) begin
      rwait_q <= 1'b1;
      rdec_q  <= decode(i_s_axi_araddr, ram_page_select_q);
    end else begin
      rwait_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rwait_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rdec_q == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rdec_q)
        DEC_CTRL: begin
          rdata_q <= {24'h000000, display_control_reg_q};
        end
        DEC_PAGE: begin
          rdata_q <= {24'h000000, ram_page_select_q};
        end
        DEC_DISP: begin
          rdata_q <= {24'h000000, cpu_rd_data};
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else if (i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sub clock sampling and frame base divider
  // ----------------------------------------------------------------
  logic         sub_meta_q;
  logic         sub_sync_q;
  logic         sub_prev_q;
  logic         sub_tick;
  logic         disp_en;
  logic [7:0]   div_last;
  logic [7:0]   div_cnt_q;
  logic         base_tick;
  logic [1:0]   com_last;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else begin
      sub_meta_q <= i_sub_clock;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  // scan timed from sub clock only
  assign sub_tick  = sub_sync_q && !sub_prev_q;
  assign disp_en   = display_control_reg_q[ENABLE_BIT];
  assign div_last  = 8'((BASE_DIV_MIN << display_control_reg_q[RATE_LSB +: 2]) - 9'h001);
  // Greater-or-equal keeps a lowered ratio from running a full wrap
  assign base_tick = disp_en && sub_tick && (div_cnt_q >= div_last);
  assign com_last  = display_control_reg_q[DUTY_LSB +: 2];

  always_ff @(posedge i_clock) begin
    if (i_rst || !disp_en) begin
      div_cnt_q <= '0;
    end else if (base_tick) begin
      div_cnt_q <= '0;
    end else if (sub_tick) begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Display fetch and common scan
  // ----------------------------------------------------------------
  lcdc_state_type       state_q;
  logic [5:0]           fetch_cnt_q;
  logic                 rd_valid_q;
  logic [5:0]           rd_idx_q;
  logic [SEG_COUNT-1:0] seg_shadow_q;
  logic [1:0]           next_com_q;
  logic                 tick_pend_q;
  logic                 latch;

  assign latch = (state_q == ST_WAIT) && tick_pend_q;

  // no low power input gates this machine
  always_ff @(posedge i_clock) begin
    if (i_rst || !disp_en) begin
      state_q     <= ST_OFF;
      fetch_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_q     <= ST_FETCH;
          fetch_cnt_q <= '0;
        end
        ST_FETCH: begin
          if (fetch_cnt_q == FETCH_LAST) begin
            state_q <= ST_WAIT;
          end
          fetch_cnt_q <= fetch_cnt_q + 6'h01;
        end
        ST_WAIT: begin
          if (latch) begin
            state_q     <= ST_FETCH;
            fetch_cnt_q <= '0;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Tick set wins over its own clear
  always_ff @(posedge i_clock) begin
    if (i_rst || !disp_en) begin
      tick_pend_q <= 1'b0;
    end else if (base_tick) begin
      tick_pend_q <= 1'b1;
    end else if (latch) begin
      tick_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rd_valid_q <= 1'b0;
      rd_idx_q   <= '0;
    end else begin
      rd_valid_q <= (state_q == ST_FETCH) && (fetch_cnt_q <= SEG_LAST);
      rd_idx_q   <= fetch_cnt_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      seg_shadow_q <= '0;
    end else if (rd_valid_q) begin
      seg_shadow_q[rd_idx_q] <= scan_rd_data[next_com_q];
    end
  end

  // ascending commons, wrapping at the duty
  always_ff @(posedge i_clock) begin
    if (i_rst || !disp_en) begin
      next_com_q <= '0;
    end else if (latch) begin
      next_com_q <= (next_com_q >= com_last) ? 2'h0 : next_com_q + 2'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || !disp_en) begin
      o_segment_outputs <= '0;
      o_common_outputs  <= '0;
      o_frame_polarity  <= 1'b0;
    end else if (latch) begin
      // shown pattern is the freshly fetched one
      o_segment_outputs <= seg_shadow_q;
      // next common index picks the one active common
      o_common_outputs  <= 4'h1 << next_com_q;
      if (next_com_q == 2'h0) begin
        o_frame_polarity <= !o_frame_polarity;
      end
    end
  end

  lcdc_disp_mem #(
    .DEPTH (DISP_DEPTH),
    .WIDTH (8),
    .AW    (6)
  ) u_mem (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_wr_en     (mem_wr),
    .i_wr_addr   (disp_index(waddr_q)),
    .i_wr_data   (wdata_q),
    .i_cpu_addr  (disp_index(i_s_axi_araddr)),
    .o_cpu_data  (cpu_rd_data),
    .i_scan_addr (fetch_cnt_q),
    .o_scan_data (scan_rd_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] hlp_subs_q;
  logic       hlp_ok_q;

  always_ff @(posedge i_clock) begin
    if (i_rst || !disp_en || ctrl_wr) begin
      hlp_subs_q <= '0;
      hlp_ok_q   <= 1'b0;
    end else if (base_tick) begin
      hlp_subs_q <= '0;
      hlp_ok_q   <= 1'b1;
    end else if (sub_tick) begin
      hlp_subs_q <= hlp_subs_q + 9'h001;
    end
  end

  property p_ctrl_reset;
    @(posedge i_clock) disable iff (i_rst)
    $fell(i_rst) |-> display_control_reg_q == CTRL_RESET && !o_common_outputs[0];
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared");

  property p_rate_write;
    @(posedge i_clock) disable iff (i_rst)
    ctrl_wr |=> display_control_reg_q[1:0] == $past(wdata_q[1:0]);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate field not stored");

  property p_divide;
    @(posedge i_clock) disable iff (i_rst)
    base_tick && hlp_ok_q |-> hlp_subs_q == {1'b0, div_last};
  endproperty
  a_divide: assert property (p_divide) else $error("base divide ratio wrong");

  property p_sub_source;
    @(posedge i_clock) disable iff (i_rst)
    $changed(div_cnt_q) && disp_en && $past(disp_en)
      |-> $past(sub_sync_q) && !$past(sub_prev_q);
  endproperty
  a_sub_source: assert property (p_sub_source) else $error("base tick without sub edge");

  property p_off;
    @(posedge i_clock) disable iff (i_rst)
    !disp_en |=> o_segment_outputs == '0 && o_common_outputs == '0 && state_q == ST_OFF;
  endproperty
  a_off: assert property (p_off) else $error("outputs live while disabled");

  property p_ascend;
    @(posedge i_clock) disable iff (i_rst)
    $changed(o_common_outputs) && o_common_outputs != 4'h1 && $past(disp_en)
      |-> o_common_outputs == ($past(o_common_outputs) << 1);
  endproperty
  a_ascend: assert property (p_ascend) else $error("commons not ascending");

  // Duty rewrite may overshoot one slot, so the next wrap is excused
  logic hlp_duty_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hlp_duty_q <= 1'b0;
    end else if (ctrl_wr && wdata_q[DUTY_LSB +: 2] != com_last) begin
      hlp_duty_q <= 1'b1;
    end else if (latch && next_com_q == 2'h0) begin
      hlp_duty_q <= 1'b0;
    end
  end

  property p_wrap;
    @(posedge i_clock) disable iff (i_rst)
    $changed(o_common_outputs) && o_common_outputs == 4'h1 && $past(o_common_outputs) != 4'h0
      && $stable(display_control_reg_q) && !$past(hlp_duty_q)
      |-> $past(o_common_outputs) == (4'h1 << com_last);
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame length not duty");

  property p_fetch_len;
    @(posedge i_clock) disable iff (i_rst)
    $rose(state_q == ST_FETCH) && disp_en |-> ##38 (state_q != ST_FETCH);
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch length wrong");

  property p_page_gate;
    @(posedge i_clock) disable iff (i_rst)
    ar_hs && i_s_axi_araddr[11:2] == DISP_FIRST_INDEX && ram_page_select_q != DISP_PAGE
      |-> ##2 o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR;
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("display read outside page");

endmodule

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the segment LCD controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb;
  import lcdc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sub = 1'b0;
  logic [2:0]  sub_q = 3'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pol;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata;
  logic [36:0] seg;
  logic [3:0]  com;
  logic [7:0]  mem [37];
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  lcdc_segment_lcd_controller uut (
    .i_clock(clk), .i_rst(rst), .i_sub_clock(sub),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_segment_outputs(seg), .o_common_outputs(com),
    .o_frame_polarity(pol)
  );

  lcdc_panel_model pm (.i_clock(clk), .i_segments(seg), .i_commons(com));

  // ----------------------------------------------------------------
  // Clocks and timeout
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  // Sub clock at one eighth of the system clock keeps frames short
  always @(posedge clk) begin
    sub_q <= sub_q + 3'h1;
    sub <= sub_q[2];
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      print_verdict();
    end
  end

  task print_verdict;
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Handshakes decided at the falling edge, where inputs are settled
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    int   n;
    n = 0;
    hb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb && n < 50) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      n++;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!hb) err_count++;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    logic ha, hr;
    int   n;
    n = 0;
    hr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr && n < 50) begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata[7:0];
      r = rresp;
      n++;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!hr) err_count++;
  endtask

  task automatic wx(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    wr(a, d, resp);
    `CHK("bresp", er, resp)
  endtask

  task automatic rx(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [7:0] v;
    rd(a, v, resp);
    `CHK("rdata", e, v)
    `CHK("rresp", er, resp)
  endtask

  function automatic logic [11:0] da(input int k);
    return {DISP_FIRST_INDEX, 2'b00} + 12'(4 * k);
  endfunction

  task automatic chk_disp;
    logic [36:0] e;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 37; k++) e[k] = mem[k][c];
      `CHK("segments", e, pm.seg_seen[c])
    end
    `CHK("common order", 0, pm.order_err)
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rx(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
    rx(PAGE_ADDR, PAGE_RESET, RESP_OKAY);
    wx(da(0), 8'h5a, RESP_SLVERR);
    rx(da(0), 8'h00, RESP_SLVERR);
    rx(12'hffc, 8'h00, RESP_SLVERR);
    wx(CTRL_ADDR, 8'hff, RESP_OKAY);
    rx(CTRL_ADDR, CTRL_MASK, RESP_OKAY);
    wx(CTRL_ADDR, 8'h00, RESP_OKAY);
    wx(PAGE_ADDR, DISP_PAGE, RESP_OKAY);
    for (int k = 0; k < 37; k++) begin
      mem[k] = 8'(k * 8'h1d + 8'h5b);
      wx(da(k), mem[k], RESP_OKAY);
    end
    for (int k = 0; k < 37; k++) rx(da(k), mem[k], RESP_OKAY);
    rx(da(37), 8'h00, RESP_SLVERR);
    // Quarter duty, fastest rate
    wx(CTRL_ADDR, 8'h1c, RESP_OKAY);
    repeat (1300) @(posedge clk);
    chk_disp();
    // Memory write alone must change the picture
    mem[0] = ~mem[0];
    wx(da(0), mem[0], RESP_OKAY);
    repeat (1300) @(posedge clk);
    chk_disp();
    for (int r = 0; r < 4; r++) begin
      wx(CTRL_ADDR, 8'h14 | 8'(r), RESP_OKAY);
      repeat (3 * (256 << r) + 100) @(posedge clk);
      `CHK("slot length", 256 << r, pm.slot_len)
    end
    for (int d = 0; d < 4; d++) begin
      wx(CTRL_ADDR, 8'h10 | 8'(d << 2), RESP_OKAY);
      repeat (600) @(posedge clk);
      @(negedge clk);
      pm.max_com = 0;
      repeat (1100) @(posedge clk);
      `CHK("highest common", d, pm.max_com)
    end
    wx(CTRL_ADDR, 8'h00, RESP_OKAY);
    repeat (600) @(posedge clk);
    `CHK("segments off", 37'h0, seg)
    `CHK("commons off", 4'h0, com)
    `CHK("polarity off", 1'b0, pol)
    print_verdict();
  end
endmodule

`default_nettype wire
